//--- common/iprc_regs.vh
// constants for the idle, power-down and reset control block
`ifndef IPRC_REGS_VH
`define IPRC_REGS_VH
// power control register bit positions
`define IPRC_PCR_IDLE_BIT 0
`define IPRC_PCR_PD_BIT 1
`define IPRC_PCR_GF0_BIT 2
`define IPRC_PCR_GF1_BIT 3
`define IPRC_PCR_SMOD_BIT 7
// register offsets on the plain register port
`define IPRC_OFF_PCR 2'h0
`define IPRC_OFF_STATUS 2'h1
`define IPRC_OFF_CTRL 2'h2
// reset values
`define IPRC_PCR_RST 8'h00
`define IPRC_CTRL_RST 8'h01
`define IPRC_ACC_RST 8'h00
`define IPRC_PORT_RST 8'hFF
`define IPRC_SP_RST 8'h07
`define IPRC_WDCTL_RST 8'hA5
// timing: oscillator periods per machine cycle
`define IPRC_OSC_PER_MC 12
`define IPRC_MC_CNT_W 4
// reset pin held high this many sampled machine cycles before reset acts
`define IPRC_RST_SAMPLES 2
// watchdog reset pulse, in watchdog oscillator cycles: 16 x 2048
`define IPRC_WD_PULSE_MULT 16
`define IPRC_WD_PULSE_BASE 2048
`endif

//--- src/iprc_mc_div.v
// machine cycle enable divider, one pulse every twelve clocks
`timescale 1ns/1ps
`default_nettype none
`include "iprc_regs.vh"
module iprc_mc_div (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // oscillator running
  input wire run,
  // machine cycle pulse
  output wire mc_tick
);
  localparam [31:0] LAST_W = `IPRC_OSC_PER_MC - 1;
  localparam [`IPRC_MC_CNT_W-1:0] LAST = LAST_W[`IPRC_MC_CNT_W-1:0];
  reg [`IPRC_MC_CNT_W-1:0] cnt_q;
  assign mc_tick = run && (cnt_q == LAST);
  always @(posedge ref_clk) begin
    if (rst) begin
      cnt_q <= {`IPRC_MC_CNT_W{1'b0}};
    end else if (run) begin
      if (cnt_q == LAST) begin
        cnt_q <= {`IPRC_MC_CNT_W{1'b0}};
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- src/iprc_top.v
// idle, power-down and reset sequencing for an 8-bit controller
`timescale 1ns/1ps
`default_nettype none
`include "iprc_regs.vh"
module iprc_top (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // register port
  input wire [1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // cpu handshake: instruction boundary and interrupt return
  input wire instr_done,
  input wire irq_accept,
  input wire ret_from_irq,
  input wire ext_mem_mode,
  // interrupt sources
  input wire ext_irq_zero_pin,
  input wire ext_irq_one_pin,
  input wire ext_irq_zero_level,
  input wire ext_irq_one_level,
  input wire ext_irq_zero_en,
  input wire ext_irq_one_en,
  input wire global_irq_en,
  input wire any_irq_pending,
  // reset sources
  input wire reset_pin,
  input wire watchdog_en,
  input wire watchdog_overflow,
  input wire wd_osc_tick,
  input wire osc_stable,
  // clock gating and reset outputs
  output wire cpu_clk_en,
  output wire periph_clk_en,
  output wire osc_run,
  output wire core_reset,
  output wire mc_tick,
  output wire resume_after_entry,
  // power state and pins
  output wire idle_active,
  output wire pd_active,
  output reg address_latch_strobe,
  output reg program_fetch_strobe,
  output reg port0_float,
  output reg port2_show_latch,
  // reset values presented to the core
  output wire [7:0] rst_acc_val,
  output wire [7:0] rst_port_val,
  output wire [7:0] rst_sp_val,
  output wire [7:0] watchdog_control_rst,
  output wire smod
);
  // ==========================================================
  // state machine
  localparam [3:0] ST_RUN = 4'b0001;
  localparam [3:0] ST_IDLE = 4'b0010;
  localparam [3:0] ST_PD = 4'b0100;
  localparam [3:0] ST_WAKE = 4'b1000;
  localparam [31:0] WD_PULSE =
    `IPRC_WD_PULSE_MULT * `IPRC_WD_PULSE_BASE;

  reg [3:0] st_q;
  reg [3:0] st_d;
  reg [7:0] pcr_q;
  reg [7:0] ctrl_q;
  reg [1:0] rst_cnt_q;
  reg rst_pin_q;
  reg [15:0] wd_cnt_q;
  reg wd_rst_q;
  reg pd_req_q;
  reg idle_req_q;
  reg resume_q;
  wire int_reset;
  wire pcr_wr;
  wire wake_pd;
  wire wake_idle;

  // ==========================================================
  // decode
  function sel;
    input [1:0] a;
    input [1:0] off;
    begin
      sel = (a == off);
    end
  endfunction

  assign pcr_wr = reg_wr && sel(reg_addr, `IPRC_OFF_PCR);

  // ==========================================================
  // machine cycle divider, halted with oscillator
  iprc_mc_div u_div (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(osc_run),
    .mc_tick(mc_tick)
  );

  // ==========================================================
  // reset pin sampling; pin sampled only on the machine cycle
  always @(posedge ref_clk) begin
    if (rst) begin
      rst_pin_q <= 1'b0;
      rst_cnt_q <= 2'b00;
    end else if (mc_tick) begin
      rst_pin_q <= reset_pin;
      if (reset_pin || wd_rst_q) begin
        if (rst_cnt_q != 2'd`IPRC_RST_SAMPLES) begin
          rst_cnt_q <= rst_cnt_q + 2'b01;
        end
      end else begin
        rst_cnt_q <= 2'b00;
      end
    end
  end

  // ==========================================================
  // watchdog reset pulse, counted on the watchdog oscillator;
  // internal path, so it acts whatever the pin level
  always @(posedge ref_clk) begin
    if (rst) begin
      wd_cnt_q <= 16'h0000;
      wd_rst_q <= 1'b0;
    end else if (watchdog_en && watchdog_overflow) begin
      wd_rst_q <= 1'b1;
      wd_cnt_q <= WD_PULSE[15:0] - 16'h0001;
    end else if (wd_rst_q && wd_osc_tick) begin
      if (wd_cnt_q == 16'h0000) begin
        wd_rst_q <= 1'b0;
      end else begin
        wd_cnt_q <= wd_cnt_q - 16'h0001;
      end
    end
  end

  // reset on the second high sample, held while pin high
  assign int_reset = rst ||
    (rst_cnt_q == 2'd`IPRC_RST_SAMPLES) || wd_rst_q;
  assign core_reset = int_reset;

  // ==========================================================
  // wake conditions
  assign wake_pd = global_irq_en &&
    ((ext_irq_zero_en && ext_irq_zero_level && !ext_irq_zero_pin) ||
     (ext_irq_one_en && ext_irq_one_level && !ext_irq_one_pin));
  assign wake_idle = global_irq_en && any_irq_pending;

  // ==========================================================
  // next state
  always @* begin
    st_d = st_q;
    case (st_q)
      ST_RUN: begin
        // mode taken only at the instruction boundary
        if (instr_done && pd_req_q) begin
          st_d = ST_PD;
        end else if (instr_done && idle_req_q) begin
          st_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (wake_idle) begin
          st_d = ST_RUN;
        end
      end
      ST_PD: begin
        if (wake_pd) begin
          st_d = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (osc_stable) begin
          st_d = ST_RUN;
        end
      end
      default: begin
        st_d = ST_RUN;
      end
    endcase
  end

  always @(posedge ref_clk) begin
    if (int_reset) begin
      st_q <= ST_RUN;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // power control register; mode bits self-clear on wake
  always @(posedge ref_clk) begin
    if (int_reset) begin
      pcr_q <= `IPRC_PCR_RST;
      pd_req_q <= 1'b0;
      idle_req_q <= 1'b0;
    end else begin
      if (pcr_wr) begin
        // flags kept by software only
        pcr_q <= reg_wdata;
        pd_req_q <= reg_wdata[`IPRC_PCR_PD_BIT];
        idle_req_q <= reg_wdata[`IPRC_PCR_IDLE_BIT];
      end else if (st_q != ST_RUN && st_d == ST_RUN) begin
        // hardware clears the mode bits on exit
        pcr_q[`IPRC_PCR_IDLE_BIT] <= 1'b0;
        pcr_q[`IPRC_PCR_PD_BIT] <= 1'b0;
      end
      if (st_q == ST_RUN && st_d != ST_RUN) begin
        pd_req_q <= 1'b0;
        idle_req_q <= 1'b0;
      end
    end
  end

  // side control register: bit 0 allows resume flag
  always @(posedge ref_clk) begin
    if (rst) begin
      ctrl_q <= `IPRC_CTRL_RST;
    end else if (reg_wr && sel(reg_addr, `IPRC_OFF_CTRL)) begin
      ctrl_q <= reg_wdata;
    end
  end

  // remember that the next return lands after the entry
  always @(posedge ref_clk) begin
    if (int_reset) begin
      resume_q <= 1'b0;
    end else if (st_q != ST_RUN && st_d == ST_RUN) begin
      resume_q <= ctrl_q[0];
    end else if (ret_from_irq) begin
      resume_q <= 1'b0;
    end
  end
  assign resume_after_entry = resume_q;

  // ==========================================================
  // register read, data one cycle later
  always @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `IPRC_OFF_PCR: reg_rdata <= pcr_q & 8'h8F;
        `IPRC_OFF_STATUS: reg_rdata <= {wd_rst_q, rst_pin_q, 2'b00, st_q};
        `IPRC_OFF_CTRL: reg_rdata <= ctrl_q;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ==========================================================
  // clocks: core frozen in idle, all frozen in power-down; a high
  // reset pin restarts the oscillator so the pin can be sampled
  assign cpu_clk_en = (st_q == ST_RUN) && !irq_accept_hold(st_q);
  assign periph_clk_en = (st_q == ST_RUN) || (st_q == ST_IDLE);
  assign osc_run = (st_q != ST_PD) || reset_pin;
  assign idle_active = (st_q == ST_IDLE);
  assign pd_active = (st_q == ST_PD) || (st_q == ST_WAKE);
  assign smod = pcr_q[`IPRC_PCR_SMOD_BIT];

  // interrupt vectoring itself happens in run; nothing to hold here
  function irq_accept_hold;
    input [3:0] s;
    begin
      irq_accept_hold = 1'b0 & s[0] & irq_accept;
    end
  endfunction

  // ==========================================================
  // pin states; registered so the data outputs are clean
  always @(posedge ref_clk) begin
    if (int_reset) begin
      address_latch_strobe <= 1'b1;
      program_fetch_strobe <= 1'b1;
      port0_float <= 1'b0;
      port2_show_latch <= 1'b1;
    end else begin
      case (st_d)
        ST_IDLE: begin
          address_latch_strobe <= 1'b1;
          program_fetch_strobe <= 1'b1;
          port0_float <= ext_mem_mode;
          port2_show_latch <= !ext_mem_mode;
        end
        ST_PD, ST_WAKE: begin
          address_latch_strobe <= 1'b0;
          program_fetch_strobe <= 1'b0;
          port0_float <= ext_mem_mode;
          port2_show_latch <= 1'b1;
        end
        default: begin
          address_latch_strobe <= 1'b0;
          program_fetch_strobe <= 1'b0;
          port0_float <= 1'b0;
          port2_show_latch <= !ext_mem_mode;
        end
      endcase
    end
  end

  // ==========================================================
  // reset load values for the core registers
  assign rst_acc_val = `IPRC_ACC_RST;
  assign rst_port_val = `IPRC_PORT_RST;
  assign rst_sp_val = `IPRC_SP_RST;
  assign watchdog_control_rst = `IPRC_WDCTL_RST;
endmodule
`default_nettype wire

//--- tb/iprc_cpu_model.sv
// cpu core and oscillator stand-in for the power control block
`timescale 1ns/1ps
`default_nettype none
module iprc_cpu_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // from the block
  input wire logic cpu_clk_en,
  input wire logic osc_run,
  // to the block
  output logic instr_done,
  output logic osc_stable
);
  // ====
  // core and oscillator
  logic [2:0] ins_q;
  logic [5:0] stb_q;
  always @(posedge ref_clk) begin
    if (rst || !cpu_clk_en) ins_q <= 3'h0;
    else ins_q <= (ins_q == 3'h4) ? 3'h0 : ins_q + 3'h1;
    instr_done <= !rst && cpu_clk_en && ins_q == 3'h4;
    // a restarted oscillator needs 40 clocks to settle
    if (!osc_run) stb_q <= 6'h00;
    else if (stb_q != 6'h28) stb_q <= stb_q + 6'h01;
    osc_stable <= osc_run && stb_q == 6'h28;
  end
endmodule
`default_nettype wire

//--- tb/iprc_checker.sv
// checker for power states and reset sequencing
`timescale 1ns/1ps
`default_nettype none
module iprc_checker (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // sources
  input wire logic global_irq_en,
  input wire logic any_irq_pending,
  input wire logic reset_pin,
  input wire logic watchdog_en,
  input wire logic watchdog_overflow,
  // watched outputs
  input wire logic cpu_clk_en,
  input wire logic periph_clk_en,
  input wire logic osc_run,
  input wire logic core_reset,
  input wire logic mc_tick,
  input wire logic idle_active,
  input wire logic pd_active,
  input wire logic address_latch_strobe,
  input wire logic program_fetch_strobe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ====
  // properties
  sequence s_pin_hi2;
    (mc_tick && reset_pin) ##12 (mc_tick && reset_pin);
  endsequence
  sequence s_strb_hi;
    address_latch_strobe && program_fetch_strobe;
  endsequence
  property p_pin_rst; s_pin_hi2 |-> ##[0:1] core_reset; endproperty
  a_pin_rst: assert property (p_pin_rst)
    else $error("pin reset missing");
  property p_wd_rst;
    watchdog_en && watchdog_overflow |-> ##[0:1] core_reset;
  endproperty
  a_wd_rst: assert property (p_wd_rst)
    else $error("watchdog reset missing");
  property p_idle_gate; idle_active |-> !cpu_clk_en && periph_clk_en;
  endproperty
  a_idle_gate: assert property (p_idle_gate)
    else $error("idle clock gating wrong");
  property p_idle_str; idle_active |-> s_strb_hi; endproperty
  a_idle_str: assert property (p_idle_str)
    else $error("idle strobes wrong");
  property p_pd_str;
    pd_active && !osc_run |-> !address_latch_strobe && !program_fetch_strobe;
  endproperty
  a_pd_str: assert property (p_pd_str)
    else $error("power-down strobes wrong");
  property p_rst_str; core_reset |=> s_strb_hi; endproperty
  a_rst_str: assert property (p_rst_str)
    else $error("reset strobes wrong");
  property p_idle_exit;
    idle_active && global_irq_en && any_irq_pending |=> !idle_active;
  endproperty
  a_idle_exit: assert property (p_idle_exit)
    else $error("idle kept on interrupt");
  property p_run;
    cpu_clk_en |-> osc_run && !idle_active && !pd_active;
  endproperty
  a_run: assert property (p_run)
    else $error("cpu clock outside run");
endmodule
bind iprc_top iprc_checker i_chk (
  .ref_clk(ref_clk),
  .rst(rst),
  .global_irq_en(global_irq_en),
  .any_irq_pending(any_irq_pending),
  .reset_pin(reset_pin),
  .watchdog_en(watchdog_en),
  .watchdog_overflow(watchdog_overflow),
  .cpu_clk_en(cpu_clk_en),
  .periph_clk_en(periph_clk_en),
  .osc_run(osc_run),
  .core_reset(core_reset),
  .mc_tick(mc_tick),
  .idle_active(idle_active),
  .pd_active(pd_active),
  .address_latch_strobe(address_latch_strobe),
  .program_fetch_strobe(program_fetch_strobe)
);
`default_nettype wire

//--- tb/test_idle_powerdown_reset_control.sv
// self-checking bench for the power control block
`timescale 1ns/1ps
`default_nettype none
module test_idle_powerdown_reset_control;
  logic ref_clk = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic rd_d1 = 1'h0, ret_from_irq = 1'h0, ext_mem_mode = 1'h0;
  logic ext_irq_zero_pin = 1'h1, ext_irq_zero_level = 1'h0;
  logic ext_irq_zero_en = 1'h0, global_irq_en = 1'h0;
  logic ext_irq_one_pin = 1'h1, ext_irq_one_level = 1'h0;
  logic ext_irq_one_en = 1'h0;
  logic any_irq_pending = 1'h0, reset_pin = 1'h0;
  logic watchdog_en = 1'h0, watchdog_overflow = 1'h0;
  wire cpu_clk_en, periph_clk_en, osc_run, core_reset, mc_tick, smod;
  wire resume_after_entry, idle_active, pd_active, address_latch_strobe;
  wire program_fetch_strobe, port0_float, port2_show_latch;
  wire instr_done, osc_stable;
  wire [7:0] reg_rdata, rst_acc_val, rst_port_val, rst_sp_val;
  wire [7:0] watchdog_control_rst;
  logic [7:0] exp_q[$], msk_q[$];
  logic [31:0] rs = 32'h8563;
  int n_fail = 0, comparisons = 0;
  iprc_top i_dut (.*, .irq_accept(1'h0), .wd_osc_tick(1'h1));
  iprc_cpu_model i_cpu (.*);
  initial forever #10 ref_clk = ~ref_clk;
  // ====
  // tasks
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic chk(input string n, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
  endtask
  // e is already masked by m
  task automatic rd(input logic [1:0] a, input logic [7:0] e, m);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge ref_clk);
    reg_rd <= 1'h0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // read data stand only in the cycle after the strobe
  always @(posedge ref_clk) rd_d1 <= reg_rd;
  always @(negedge ref_clk)
    if (rd_d1) chk("reg_rdata", exp_q.pop_front(), reg_rdata & msk_q.pop_front());
  initial begin
    #1000000;
    n_fail++;
    tally_and_finish;
  end
  // ====
  // scenarios
  initial begin
    cyc(16);
    rst <= 1'h0;
    rd(0, 8'h00, 8'h8F);
    rd(2, 8'h01, 8'hFF);
    rd(3, 8'h00, 8'hFF);
    rd(1, 8'h01, 8'h0F);
    chk("rst_vals", 32'h00FF07A5, {rst_acc_val, rst_port_val,
      rst_sp_val, watchdog_control_rst});
    repeat (4) begin
      rs = xs(rs);
      wr(0, rs[7:0] & 8'hFC);
      rd(0, rs[7:0] & 8'h8C, 8'hFF);
      chk("smod", rs[7], smod);
    end
    wr(0, 8'h05);
    cyc(12);
    rd(1, 8'h02, 8'h0F);
    global_irq_en <= 1'h1;
    any_irq_pending <= 1'h1;
    cyc(3);
    any_irq_pending <= 1'h0;
    rd(1, 8'h01, 8'h0F);
    rd(0, 8'h04, 8'h8F);
    // one sample high only: no reset
    reset_pin <= 1'h1;
    cyc(12);
    reset_pin <= 1'h0;
    rd(0, 8'h04, 8'h8F);
    ext_mem_mode <= 1'h1;
    ext_irq_zero_en <= 1'h1;
    wr(0, 8'h07);
    cyc(12);
    rd(1, 8'h04, 8'h0F);
    @(negedge ref_clk);
    chk("osc_run", 0, osc_run);
    chk("port2_show_latch", 1, port2_show_latch);
    chk("port0_float", 1, port0_float);
    @(posedge ref_clk);
    ext_irq_zero_pin <= 1'h0;
    cyc(8);
    rd(1, 8'h04, 8'h0F);
    // held low until the oscillator settles
    ext_irq_zero_level <= 1'h1;
    cyc(80);
    ext_irq_zero_pin <= 1'h1;
    rd(1, 8'h01, 8'h0F);
    rd(0, 8'h04, 8'h8F);
    @(negedge ref_clk);
    chk("resume", 1, resume_after_entry);
    @(posedge ref_clk);
    ret_from_irq <= 1'h1;
    cyc(1);
    ret_from_irq <= 1'h0;
    @(negedge ref_clk);
    chk("resume", 0, resume_after_entry);
    wr(0, 8'h01);
    cyc(12);
    watchdog_en <= 1'h1;
    watchdog_overflow <= 1'h1;
    cyc(1);
    watchdog_overflow <= 1'h0;
    rd(1, 8'h81, 8'h8F);
    cyc(32700);
    rd(1, 8'h81, 8'h8F);
    cyc(80);
    rd(1, 8'h01, 8'h8F);
    rd(0, 8'h00, 8'h8F);
    wr(0, 8'h02);
    cyc(12);
    rd(1, 8'h04, 8'h0F);
    reset_pin <= 1'h1;
    cyc(60);
    reset_pin <= 1'h0;
    cyc(80);
    rd(1, 8'h01, 8'h0F);
    rd(0, 8'h00, 8'h8F);
    // second wake source, level-sensitive and enabled
    ext_irq_one_en <= 1'h1;
    ext_irq_one_level <= 1'h1;
    wr(0, 8'h02);
    cyc(12);
    rd(1, 8'h04, 8'h0F);
    ext_irq_one_pin <= 1'h0;
    cyc(80);
    ext_irq_one_pin <= 1'h1;
    rd(1, 8'h01, 8'h0F);
    cyc(4);
    tally_and_finish;
  end
endmodule
`default_nettype wire
